// ==== sef_pkg.sv ====
// sef_pkg: constants, opcodes and states of the serial eeprom front end
// assumes a 50 MHz system clock that oversamples the serial pins
`default_nettype none
package sef_pkg;
	// clock and self-timed status update
	localparam int CLK_PERIOD_NS = 20;
	localparam int T_WRITE_NS = 5_000_000;
	// longest time, so round down
	localparam int WRITE_CYC = T_WRITE_NS / CLK_PERIOD_NS;

	// instruction byte: upper nibble must be zero, bit 3 is the top address bit for read and write, else don't care
	localparam logic [3:0] OP_HI = 4'h0;
	localparam int OP_XBIT = 3;
	localparam logic [2:0] OP_ARM = 3'h6;
	localparam logic [2:0] OP_DISARM = 3'h4;
	localparam logic [2:0] OP_POLL = 3'h5;
	localparam logic [2:0] OP_UPDATE = 3'h1;
	localparam logic [2:0] OP_READ = 3'h3;
	localparam logic [2:0] OP_WRITE = 3'h2;

	// status word layout
	localparam int SW_BUSY = 0;
	localparam int SW_ARM = 1;
	localparam int SW_GLO = 2;
	localparam int SW_GHI = 3;
	localparam logic [1:0] GUARD_RST = 2'h0;
	localparam logic [2:0] BIT_LAST = 3'h7;

	// protected region base addresses
	localparam int ADDR_W = 9;
	localparam logic [ADDR_W-1:0] PROT_QTR = 9'h180;
	localparam logic [ADDR_W-1:0] PROT_HALF = 9'h100;
	localparam logic [ADDR_W-1:0] PROT_ALL = 9'h000;

	// front end states, one-hot
	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_CMD = 7'h02,
		ST_WAIT = 7'h04,
		ST_POLL = 7'h08,
		ST_UPD = 7'h10,
		ST_UPDE = 7'h20,
		ST_ARR = 7'h40
	} sef_state_t;
endpackage : sef_pkg
`default_nettype wire

// ==== sef_front_end.sv ====
// sef_front_end: serial command front end, status word, update cycle
// assumes all serial pins are asynchronous to i_clk and much slower
// Overview of operation
// - serial output bit changes after a falling serial clock edge
// - instruction, address and data bits captured on rising serial clock
// - unit-select high deselects, floats output, standby unless cycle runs
// - no instruction is taken until a falling unit-select edge is seen
// - pause floats output and ignores input and clock, stays selected
// - lock pin low blocks array write and update instructions
// - lock pin change never aborts a running internal cycle
// - unknown instruction code makes the unit ignore input until reselected
// - arm 0000x110, disarm 0000x100, poll 0000x101, x ignored
// - update 0000x001, read 0000A011, write 0000A010, A top address
// - only the arm command sets the arm flag, at its decode
// - after arm or disarm byte the unit waits for deselection
// - arm flag cleared by reset, disarm, cycle end and lock falling
// - poll accepted anytime, status repeats while clocking continues
// - status busy bit is one exactly while a write or update cycle runs, o_busy_flag one clock later
// - with arm flag clear, array write and update are rejected
// - guard bits change only by update or reset; update taken only without hardware lock
// - update ignores bits 7..4,1,0; bits 7..4 read zero
// - extra clock after update data byte discards the update
// - deselect after valid update starts a timed cycle, then clears arm
// - old guard bits apply until the update cycle completes
// - guard 00 none, 01 upper quarter, 10 upper half, 11 all
// - pause pin enters and leaves pause only while the serial clock is low; deselect ends pause at once
`timescale 1ns/1ps
`default_nettype none
module sef_front_end #(
	parameter int WRITE_TIME_CYC = sef_pkg::WRITE_CYC
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// serial pins
	input wire logic i_sck,
	input wire logic i_cs_n,
	input wire logic i_sdi,
	input wire logic i_pause_n,
	input wire logic i_lock_n,
	output logic o_sdo,
	output logic o_sdo_oe_n,
	// array sequencer hand-off
	input wire logic i_arr_busy,
	input wire logic i_arr_done,
	output logic o_arr_rd_go,
	output logic o_arr_wr_go,
	output logic o_top_addr_bit,
	// status and protection
	output logic o_busy_flag,
	output logic o_arm_flag,
	output logic o_guard_hi,
	output logic o_guard_lo,
	output logic o_prot_en,
	output logic [sef_pkg::ADDR_W-1:0] o_prot_base,
	output logic o_standby
);
	import sef_pkg::*;

	localparam int TW = $clog2(WRITE_TIME_CYC + 1);

	typedef struct packed {
		logic cs_s1;
		logic cs_s2;
		logic cs_d;
		logic ck_s1;
		logic ck_s2;
		logic ck_d;
		logic di_s1;
		logic di_s2;
		logic hd_s1;
		logic hd_s2;
		logic hd_d;
		logic wp_s1;
		logic wp_s2;
		logic wp_d;
		logic paused;
		sef_state_t fsm;
		logic [2:0] bit_cnt;
		logic [7:0] in_sr;
		logic [7:0] out_sr;
		logic [2:0] out_cnt;
		logic drv;
		logic arm;
		logic upd_busy;
		logic [TW-1:0] timer;
		logic [1:0] guard;
		logic [1:0] pend;
		logic sdo;
		logic sdo_oe_n;
		logic rd_go;
		logic wr_go;
		logic top;
		logic busy_o;
		logic prot_en;
		logic [ADDR_W-1:0] prot_base;
		logic standby;
	} sef_regs_t;

	sef_regs_t r_ff;
	sef_regs_t nxt_r;

	////////////////////////////////////////////////////////////////////////
	// helpers

	// write-type instructions need arm, no lock and no running cycle
	function automatic logic wr_ok(input logic arm, input logic lock_hi,
		input logic busy);
	begin
		wr_ok = arm & lock_hi & ~busy;
	end
	endfunction : wr_ok

	// lowest protected address for each guard setting
	function automatic logic [ADDR_W-1:0] prot_base_f(input logic [1:0] g);
	begin
		case (g)
			2'h1: prot_base_f = PROT_QTR;
			2'h2: prot_base_f = PROT_HALF;
			default: prot_base_f = PROT_ALL;
		endcase
	end
	endfunction : prot_base_f

	// edge events, all taken from the second sync stage onward
	logic sel;
	logic ck_rise;
	logic ck_fall;
	logic cs_fall;
	logic cs_rise;
	logic act;
	logic busy;
	logic last_bit;
	logic [7:0] byte_in;
	logic [7:0] status;

	assign sel = ~r_ff.cs_s2;
	assign ck_rise = r_ff.ck_s2 & ~r_ff.ck_d;
	assign ck_fall = ~r_ff.ck_s2 & r_ff.ck_d;
	assign cs_fall = ~r_ff.cs_s2 & r_ff.cs_d;
	assign cs_rise = r_ff.cs_s2 & ~r_ff.cs_d;
	assign act = sel & ~r_ff.paused;
	assign busy = r_ff.upd_busy | i_arr_busy;
	assign last_bit = ck_rise & act & (r_ff.bit_cnt == BIT_LAST);
	assign byte_in = {r_ff.in_sr[6:0], r_ff.di_s2};
	// upper nibble reads zero whatever was written
	assign status = {4'h0, r_ff.guard, r_ff.arm, busy};

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb
	begin
		nxt_r = r_ff;
		// two-stage synchronisers and edge delays
		nxt_r.cs_s1 = i_cs_n;
		nxt_r.cs_s2 = r_ff.cs_s1;
		nxt_r.cs_d = r_ff.cs_s2;
		nxt_r.ck_s1 = i_sck;
		nxt_r.ck_s2 = r_ff.ck_s1;
		nxt_r.ck_d = r_ff.ck_s2;
		nxt_r.di_s1 = i_sdi;
		nxt_r.di_s2 = r_ff.di_s1;
		nxt_r.hd_s1 = i_pause_n;
		nxt_r.hd_s2 = r_ff.hd_s1;
		nxt_r.hd_d = r_ff.hd_s2;
		nxt_r.wp_s1 = i_lock_n;
		nxt_r.wp_s2 = r_ff.wp_s1;
		nxt_r.wp_d = r_ff.wp_s2;
		nxt_r.rd_go = 1'b0;
		nxt_r.wr_go = 1'b0;

		// self-timed update: lock has no say here
		if (r_ff.upd_busy)
		begin
			if (r_ff.timer == TW'(1))
			begin
				nxt_r.upd_busy = 1'b0;
				nxt_r.guard = r_ff.pend;
				nxt_r.arm = 1'b0;
			end
			else
				nxt_r.timer = r_ff.timer - TW'(1);
		end
		// clears come first so a same-cycle arm decode still wins
		if (i_arr_done || (r_ff.wp_d && !r_ff.wp_s2))
			nxt_r.arm = 1'b0;

		// pause pin only enters or leaves pause while the serial clock is low
		if (sel && !r_ff.ck_s2 && r_ff.hd_d && !r_ff.hd_s2)
			nxt_r.paused = 1'b1;
		if (!r_ff.ck_s2 && !r_ff.hd_d && r_ff.hd_s2)
			nxt_r.paused = 1'b0;

		// selection starts a command; no fall, no command
		if (cs_fall)
		begin
			nxt_r.fsm = ST_CMD;
			nxt_r.bit_cnt = 3'h0;
		end

		// capture on rising serial clock
		if (ck_rise && act)
		begin
			nxt_r.in_sr = byte_in;
			nxt_r.bit_cnt = r_ff.bit_cnt + 3'h1;
			case (r_ff.fsm)
				ST_CMD:
				begin
					if (last_bit)
					begin
						// anything outside the set parks until deselect
						nxt_r.fsm = ST_WAIT;
						if (byte_in[7:4] == OP_HI)
						begin
							// bit 3 only matters for array access
							case (byte_in[2:0])
								OP_ARM:
									nxt_r.arm = 1'b1;
								OP_DISARM:
									nxt_r.arm = 1'b0;
								OP_POLL:
								begin
									nxt_r.fsm = ST_POLL;
									nxt_r.out_sr = status;
									nxt_r.out_cnt = 3'h0;
									nxt_r.drv = 1'b0;
								end
								OP_UPDATE:
								begin
									if (wr_ok(r_ff.arm, r_ff.wp_s2, busy))
										nxt_r.fsm = ST_UPD;
								end
								OP_READ:
								begin
									if (!busy)
									begin
										nxt_r.fsm = ST_ARR;
										nxt_r.rd_go = 1'b1;
										nxt_r.top = byte_in[OP_XBIT];
									end
								end
								OP_WRITE:
								begin
									if (wr_ok(r_ff.arm, r_ff.wp_s2, busy))
									begin
										nxt_r.fsm = ST_ARR;
										nxt_r.wr_go = 1'b1;
										nxt_r.top = byte_in[OP_XBIT];
									end
								end
								default:
									nxt_r.fsm = ST_WAIT;
							endcase
						end
					end
				end
				ST_UPD:
				begin
					if (last_bit)
					begin
						// only the guard field of the data byte is kept
						nxt_r.pend = byte_in[SW_GHI:SW_GLO];
						nxt_r.fsm = ST_UPDE;
					end
				end
				// one more rising edge throws the update away
				ST_UPDE:
					nxt_r.fsm = ST_WAIT;
				default:
					nxt_r.fsm = r_ff.fsm;
			endcase
		end

		// shift out on falling serial clock, byte after byte
		if (ck_fall && act && r_ff.fsm == ST_POLL)
		begin
			nxt_r.sdo = r_ff.out_sr[7];
			nxt_r.drv = 1'b1;
			nxt_r.out_cnt = r_ff.out_cnt + 3'h1;
			if (r_ff.out_cnt == BIT_LAST)
				nxt_r.out_sr = status;
			else
				nxt_r.out_sr = {r_ff.out_sr[6:0], 1'b0};
		end

		// deselect: start a valid update, drop everything else
		if (cs_rise && r_ff.fsm == ST_UPDE && !busy)
		begin
			nxt_r.upd_busy = 1'b1;
			nxt_r.timer = TW'(WRITE_TIME_CYC);
		end
		if (!sel)
		begin
			nxt_r.fsm = ST_IDLE;
			nxt_r.paused = 1'b0;
			nxt_r.bit_cnt = 3'h0;
		end

		// output enable follows selection, pause and poll state
		nxt_r.sdo_oe_n = ~(act & (r_ff.fsm == ST_POLL) & nxt_r.drv);
		nxt_r.busy_o = busy;
		nxt_r.prot_en = |r_ff.guard;
		nxt_r.prot_base = prot_base_f(r_ff.guard);
		nxt_r.standby = ~sel & ~busy;
	end

	////////////////////////////////////////////////////////////////////////
	// state register

	// guard bits take their stored default only at reset
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			r_ff <= '0;
			r_ff.fsm <= ST_IDLE;
			r_ff.sdo_oe_n <= 1'b1;
			r_ff.guard <= GUARD_RST;
		end
		else
			r_ff <= nxt_r;
	end

	// outputs, all straight from the state register
	assign o_sdo = r_ff.sdo;
	assign o_sdo_oe_n = r_ff.sdo_oe_n;
	assign o_arr_rd_go = r_ff.rd_go;
	assign o_arr_wr_go = r_ff.wr_go;
	assign o_top_addr_bit = r_ff.top;
	assign o_busy_flag = r_ff.busy_o;
	assign o_arm_flag = r_ff.arm;
	assign o_guard_hi = r_ff.guard[1];
	assign o_guard_lo = r_ff.guard[0];
	assign o_prot_en = r_ff.prot_en;
	assign o_prot_base = r_ff.prot_base;
	assign o_standby = r_ff.standby;

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	sequence s_cmd_byte(logic [2:0] op);
		last_bit && r_ff.fsm == ST_CMD && byte_in[7:4] == OP_HI
			&& byte_in[2:0] == op;
	endsequence

	sequence s_upd_go;
		cs_rise && r_ff.fsm == ST_UPDE && !busy;
	endsequence

	AST_SDO_ON_FALL: assert property (
		$changed(r_ff.sdo) |-> $past(ck_fall))
		else $error("serial output moved without a falling clock");

	AST_FLOAT_DESEL: assert property (
		!sel ##1 !sel |-> o_sdo_oe_n)
		else $error("output driven while deselected");

	AST_PAUSE_FLOAT: assert property (
		r_ff.paused |=> o_sdo_oe_n)
		else $error("output driven while paused");

	AST_LOCK_BLOCKS_WR: assert property (
		o_arr_wr_go |-> $past(r_ff.wp_s2) && $past(r_ff.arm))
		else $error("array write passed while locked or disarmed");

	AST_ARM_SETS: assert property (
		s_cmd_byte(OP_ARM) |=> r_ff.arm && r_ff.fsm != ST_CMD)
		else $error("arm command did not set arm and wait");

	AST_BAD_OPCODE: assert property (
		last_bit && r_ff.fsm == ST_CMD && byte_in[7:4] != OP_HI && sel
		|=> r_ff.fsm == ST_WAIT)
		else $error("invalid opcode not ignored");

	AST_DISARMED_UPD: assert property (
		s_cmd_byte(OP_UPDATE) ##0 !r_ff.arm && sel |=> r_ff.fsm == ST_WAIT)
		else $error("update accepted with arm clear");

	AST_UPD_START: assert property (
		s_upd_go |=> r_ff.upd_busy ##1 o_busy_flag)
		else $error("update cycle did not start on deselect");

	AST_GUARD_FROZEN: assert property (
		r_ff.upd_busy && r_ff.timer != TW'(1) |=> $stable(r_ff.guard))
		else $error("guard bits changed mid update");

	AST_UPD_END_DISARM: assert property (
		r_ff.upd_busy && r_ff.timer == TW'(1) |=> !r_ff.arm ##1 !o_busy_flag
			|| i_arr_busy)
		else $error("update end did not clear arm and busy");

	AST_EXTRA_CLK: assert property (
		ck_rise && act && r_ff.fsm == ST_UPDE && sel |=> r_ff.fsm == ST_WAIT)
		else $error("update kept after extra clock");
endmodule : sef_front_end
`default_nettype wire

// ==== sef_host.sv ====
// sef_host: mode 0 serial host model facing the front end pins
// assumes i_clk at 50 MHz; pins move 1 ns after its rising edge
`timescale 1ns/1ps
`default_nettype none
module sef_host (
	// clock
	input wire logic i_clk,
	// serial pins
	input wire logic i_sdo,
	input wire logic i_sdo_oe_n,
	output logic o_sck,
	output logic o_cs_n,
	output logic o_sdi
);
	// select low from the start: no falling edge seen at power-up
	initial
	begin
		o_sck = 1'b0;
		o_cs_n = 1'b0;
		o_sdi = 1'b0;
	end
	////////////////////////////////////////
	// four clocks make half of a 160 ns serial period
	task automatic half();
		repeat (4) @(posedge i_clk);
		#1;
	endtask : half
	// select changes only while sck is low
	task automatic sel(input logic lvl);
		o_cs_n = lvl;
		half();
		half();
	endtask : sel
	// msb first, data set while sck low, output read at the rise
	task automatic bits(input logic [7:0] tx, input int n,
		output logic [7:0] rx);
		logic b;
		b = 1'b0;
		rx = 8'h00;
		for (int i = 7; i > 7 - n; i--)
		begin
			o_sdi = tx[i];
			half();
			o_sck = 1'b1;
			b = i_sdo_oe_n ? ~b : i_sdo; // floated reads as flipped
			rx[i] = b;
			half();
			o_sck = 1'b0;
		end
		o_sdi = ~o_sdi; // released line does not keep its value
	endtask : bits
endmodule : sef_host
`default_nettype wire

// ==== sef_front_end_tb_top.sv ====
// sef_front_end_tb_top: self-checking bench for the serial front end
// assumes sef_host drives the serial pins in mode 0
`timescale 1ns/1ps
`default_nettype none
module sef_front_end_tb_top;
	import sef_pkg::*;
	localparam int WT = 400; // short update cycle keeps the run brief
	logic i_clk = 1'b0;
	logic i_rst, i_pause_n, i_lock_n, i_arr_busy, i_arr_done;
	wire logic sck, cs_n, sdi, sdo, oe_n, rd_go, wr_go, top, busy, arm;
	wire logic ghi, glo, prot_en, stby;
	wire logic [ADDR_W-1:0] base;
	logic [7:0] rx;
	logic [1:0] go;
	int n_errors = 0;
	int n_tests = 0;
	sef_front_end #(.WRITE_TIME_CYC(WT)) sef_front_end_i (.i_clk(i_clk),
		.i_rst(i_rst), .i_sck(sck), .i_cs_n(cs_n), .i_sdi(sdi),
		.i_pause_n(i_pause_n), .i_lock_n(i_lock_n), .o_sdo(sdo),
		.o_sdo_oe_n(oe_n), .i_arr_busy(i_arr_busy),
		.i_arr_done(i_arr_done), .o_arr_rd_go(rd_go), .o_arr_wr_go(wr_go),
		.o_top_addr_bit(top), .o_busy_flag(busy), .o_arm_flag(arm),
		.o_guard_hi(ghi), .o_guard_lo(glo), .o_prot_en(prot_en),
		.o_prot_base(base), .o_standby(stby));
	sef_host host (.i_clk(i_clk), .i_sdo(sdo), .i_sdo_oe_n(oe_n),
		.o_sck(sck), .o_cs_n(cs_n), .o_sdi(sdi));
	// 20 ns system clock
	always #10 i_clk = ~i_clk;
	// one-cycle go pulses are caught here
	always @(posedge i_clk) go <= go | {wr_go, rd_go};
	////////////////////////////////////////
	task automatic chk(input string nm, input logic [8:0] got, exp);
		n_tests++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic wt(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask : wt
	task automatic cmd(input logic [7:0] op);
		host.sel(1'b0);
		host.bits(op, 8, rx);
		host.sel(1'b1);
	endtask : cmd
	// update with x stray clocks after the data byte
	task automatic upd(input logic [7:0] d, input int x);
		host.sel(1'b0);
		host.bits(8'h01, 8, rx);
		host.bits(d, 8, rx);
		host.bits(8'h00, x, rx);
		host.sel(1'b1);
	endtask : upd
	task automatic poll(input logic [7:0] exp);
		host.sel(1'b0);
		host.bits(8'h05, 8, rx);
		repeat (2)
		begin
			host.bits(8'h00, 8, rx);
			chk("status", rx, exp);
		end
		host.sel(1'b1);
	endtask : poll
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : stop_test
	////////////////////////////////////////
	initial
	begin
		i_rst = 1'b1;
		i_pause_n = 1'b1;
		i_lock_n = 1'b1;
		i_arr_busy = 1'b0;
		i_arr_done = 1'b0;
		go = 2'b00;
		wt(8);
		i_rst = 1'b0;
		wt(4);
		host.bits(8'h05, 8, rx);
		host.bits(8'h00, 8, rx);
		chk("oe_n no edge", oe_n, 1'b1);
		host.sel(1'b1);
		chk("standby", stby, 1'b1);
		poll(8'h00);
		$display("test reset done");
		for (int x = 0; x < 2; x++)
		begin
			cmd(x ? 8'h0E : 8'h06);
			chk("arm", arm, 1'b1);
			cmd(x ? 8'h0C : 8'h04);
			chk("disarm", arm, 1'b0);
		end
		host.sel(1'b0);
		host.bits(8'h86, 8, rx);
		host.bits(8'h06, 8, rx);
		host.sel(1'b1);
		chk("bad code", arm, 1'b0);
		upd(8'h0C, 0);
		poll(8'h00);
		$display("test commands done");
		// stray bits 7..4 and 1..0 are set on purpose
		for (int g = 1; g < 5; g++)
		begin
			cmd(8'h06);
			upd({4'hF, 2'(g), 2'h3}, 0);
			chk("busy", busy, 1'b1);
			chk("standby", stby, 1'b0);
			poll({4'h0, 2'(g - 1), 2'h3});
			wt(WT);
			poll({4'h0, 2'(g), 2'h0});
			chk("prot_en", prot_en, 2'(g) != 0);
			chk("base", base, g == 1 ? 9'h180 :
				g == 2 ? 9'h100 : 9'h000);
		end
		i_arr_busy = 1'b1;
		wt(3);
		chk("arr busy", busy, 1'b1);
		i_arr_busy = 1'b0;
		wt(3);
		chk("arr idle", busy, 1'b0);
		$display("test update done");
		cmd(8'h06);
		i_lock_n = 1'b0;
		wt(6);
		chk("lock arm", arm, 1'b0);
		cmd(8'h06);
		upd(8'h04, 0);
		wt(WT);
		chk("locked", {ghi, glo}, 2'h0);
		i_lock_n = 1'b1;
		cmd(8'h06);
		upd(8'h08, 0);
		i_lock_n = 1'b0;
		wt(WT);
		i_lock_n = 1'b1;
		chk("lock in cycle", {ghi, glo}, 2'h2);
		cmd(8'h06);
		upd(8'h0C, 1);
		wt(WT);
		chk("stray clock", {ghi, glo}, 2'h2);
		cmd(8'h06);
		go = 2'b00;
		cmd(8'h0A);
		chk("wr go", go, 2'b10);
		chk("top", top, 1'b1);
		i_arr_done = 1'b1;
		wt(1);
		i_arr_done = 1'b0;
		wt(3);
		chk("done arm", arm, 1'b0);
		go = 2'b00;
		cmd(8'h03);
		chk("rd go", go, 2'b01);
		chk("top", top, 1'b0);
		go = 2'b00;
		cmd(8'h02);
		chk("unarmed wr", go, 2'b00);
		$display("test lock done");
		// reset in mid-run drops arm and the stored guard bits
		cmd(8'h06);
		i_rst = 1'b1;
		wt(8);
		i_rst = 1'b0;
		wt(4);
		chk("rst arm", arm, 1'b0);
		chk("rst guard", {ghi, glo}, 2'h0);
		chk("rst busy", busy, 1'b0);
		poll(8'h00);
		$display("test reset again done");
		host.sel(1'b0);
		host.bits(8'h05, 8, rx);
		host.bits(8'h00, 1, rx);
		wt(6);
		chk("oe_n on", oe_n, 1'b0);
		i_pause_n = 1'b0;
		wt(6);
		chk("oe_n pause", oe_n, 1'b1);
		i_pause_n = 1'b1;
		host.sel(1'b1);
		chk("oe_n off", oe_n, 1'b1);
		$display("test pins done");
		stop_test();
	end
	// the whole run needs well under a millisecond
	initial
	begin
		#2_000_000;
		n_errors++;
		stop_test();
	end
endmodule : sef_front_end_tb_top
`default_nettype wire
